/* File: ccu_compare_capture.sv */
`timescale 1ns/1ps
// Summary of operation
// - General timer, 2-bit prescaler, reload, osc/12
// - Compare timer, 8-bit prescaler, reload, osc/2
// - Fifteen compare registers, five also capture
// - Each general compare register picks its timer
// - Other compare registers use general timer only
// - Match drives configured output; general-timer general, set and clear matches request interrupt
// - Mode 0: match sets, overflow clears output
// - Mode 1: software level, overflow ignored
// - Set match drives masked port-5 pins high
// - Clear match drives masked port-5 pins low
// - Port-5 writable and readable by software
// - Compare-timer general matches use shadows reloaded at overflow
// - Capture pin edge copies general timer
// - Low byte write captures general timer
// - Reload value joins reload register bytes
// - Reload mode 0: reload on overflow
// - Reload mode 1: pin falling edge, interrupt
// - 21 output lines, thirteen interrupt sources
// - Overflow/ext reload shared; general matches shared
// - Compare overflow, set, clear own requests
// - Port-1 pins shared with external interrupts
module ccu_compare_capture
	import ccu_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// General timer configuration
	input  wire logic       t2_run,
	input  wire logic [1:0] t2_pre_div,
	input  wire logic       reload_en,
	input  wire logic       reload_mode,
	input  wire logic       ext_reload_irq_en,
	input  wire logic       ext_reload_pin,
	// Compare timer configuration
	input  wire logic       ct_run,
	input  wire logic [7:0] ct_pre_div,
	// Compare/capture channel configuration
	input  wire logic [4:0] cc_cmp_en,
	input  wire logic [4:0] cc_cmp_mode,
	input  wire logic [4:0] cc_level,
	input  wire logic [4:0] cap_en,
	input  wire logic [4:0] cap_mode,
	input  wire logic [3:0] cap_rise,
	input  wire logic [3:0] capture_input,
	// General compare configuration
	input  wire logic [7:0] cm_en,
	input  wire logic [7:0] cm_sel,
	input  wire logic [7:0] cm_level,
	input  wire logic       cm2_en,
	input  wire logic [7:0] port5_pin,
	// Output lines
	output logic      [4:0] cc_out_pin,
	output logic      [7:0] cm_out_pin,
	output logic      [7:0] port5_out,
	// Event flags and their clears
	output logic            general_timer_overflow_flag,
	output logic            ext_reload_flag,
	output logic      [7:0] general_compare_match_flag,
	output logic            compare_timer_overflow_flag,
	output logic            set_match_flag,
	output logic            clear_match_flag,
	input  wire logic       t2_ovf_clr,
	input  wire logic       ext_reload_clr,
	input  wire logic [7:0] cm_match_clr,
	input  wire logic       ct_ovf_clr,
	input  wire logic       set_match_clr,
	input  wire logic       clear_match_clr,
	// Interrupt requests
	output logic            irq_t2,
	output logic            irq_cm,
	output logic            irq_ct,
	output logic            irq_set,
	output logic            irq_clr
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [4:0][15:0] cap_cmp;          // 0: reload_capture_compare_reg
		logic [7:0][15:0] general_compare_regs;
		logic [7:0][15:0] shadow;           // Compare timer compare latches
		logic [15:0]      set_val;          // Set compare value
		logic [15:0]      clr_val;          // Clear compare value
		logic [15:0]      ct_rel;           // Compare timer reload
		logic [7:0]       port5_set_mask;
		logic [7:0]       port5_clear_mask;
		logic [7:0]       port_five_reg;
		logic [4:0]       cc_out;
		logic [7:0]       cm_out;
		logic             t2_flag;
		logic             ext_flag;
		logic [7:0]       cm_flag;
		logic             ct_flag;
		logic             set_flag;
		logic             clr_flag;
		logic [3:0]       cap_prev;         // Capture pin history
		logic             ext_prev;         // Reload pin history
		logic [7:0]       rdata;
	} ccu_state_s;

	ccu_state_s  r;
	ccu_state_s  next_r;

	logic [15:0] t2_cnt;        // General timer count
	logic        t2_ovf;        // General timer overflow
	logic        t2_upd;        // General count just changed
	logic [15:0] ct_cnt;        // Compare timer count
	logic        ct_ovf;        // Compare timer overflow
	logic        ct_upd;
	logic        t2_wr_lo;
	logic        t2_wr_hi;
	logic        t2_load;
	logic [15:0] reload_value;
	logic        ext_fall;      // Reload pin falling edge
	logic        port5_wr;
	logic [4:0]  cc_hit;
	logic [7:0]  cm_hit;
	logic [7:0]  cm_t2_hit;     // General matches on general timer
	logic        set_hit;
	logic        clr_hit;
	logic [3:0]  cap_edge;
	logic [3:0]  cap_go;        // Pin capture taken
	logic [4:0]  cc_m0_set;     // Mode 0 channels matching
	logic [4:0]  cc_m0_clr;     // Mode 0 channels not matching
	logic [4:0]  cc_m1;         // Mode 1 channels matching
	logic [4:0]  m1_sel;        // Mode 1 channels enabled

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Match on a freshly changed count
	function automatic logic hit(input logic upd, input logic [15:0] cnt,
	                             input logic [15:0] val);
		return upd && (cnt == val);
	endfunction : hit

	// Register write decode
	function automatic logic wsel(input logic wr, input logic [7:0] addr,
	                              input logic [7:0] a);
		return wr && (addr == a);
	endfunction : wsel

	// ------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------
	assign t2_wr_lo     = wsel(sfr_wr, sfr_addr, ADDR_T2_LO);
	assign t2_wr_hi     = wsel(sfr_wr, sfr_addr, ADDR_T2_HI);
	assign reload_value = r.cap_cmp[0];
	assign ext_fall     = r.ext_prev && !ext_reload_pin;
	// Auto reload or pin reload
	assign t2_load      = reload_en && ((t2_ovf && !reload_mode)
	                    || (ext_fall && reload_mode));

	// General timer
	ccu_timer #(
		.BASE_DIV (T2_BASE_DIV),
		.PRE_W    (T2_PRE_W)
	) u_t2 (
		.clk      (clk),
		.rst_b    (rst_b),
		.run      (t2_run),
		.pre_div  (t2_pre_div),
		.load     (t2_load),
		.load_val (reload_value),
		.wr_lo    (t2_wr_lo),
		.wr_hi    (t2_wr_hi),
		.wdata    (sfr_wdata),
		.cnt      (t2_cnt),
		.ovf      (t2_ovf),
		.upd      (t2_upd)
	);

	// Compare timer, reloads at every overflow
	ccu_timer #(
		.BASE_DIV (CT_BASE_DIV),
		.PRE_W    (CT_PRE_W)
	) u_ct (
		.clk      (clk),
		.rst_b    (rst_b),
		.run      (ct_run),
		.pre_div  (ct_pre_div),
		.load     (ct_ovf),
		.load_val (r.ct_rel),
		.wr_lo    (1'b0),
		.wr_hi    (1'b0),
		.wdata    (8'h00),
		.cnt      (ct_cnt),
		.ovf      (ct_ovf),
		.upd      (ct_upd)
	);

	// ------------------------------------------------------------
	// Match and edge detection
	// ------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 5; i++)
		begin
			cc_hit[i] = hit(t2_upd, t2_cnt, r.cap_cmp[i]);
		end
		for (int i = 0; i < 8; i++)
		begin
			// Compare timer side uses the shadow latch
			cm_hit[i] = cm_en[i] && (cm_sel[i] ? hit(ct_upd, ct_cnt, r.shadow[i])
			          : hit(t2_upd, t2_cnt, r.general_compare_regs[i]));
		end
		for (int i = 0; i < 4; i++)
		begin
			// Capture pins share port-1 with interrupt inputs
			cap_edge[i] = cap_rise[i] ? (!r.cap_prev[i] && capture_input[i])
			            : (r.cap_prev[i] && !capture_input[i]);
			cap_go[i]   = cap_en[i] && !cap_mode[i] && cap_edge[i];
		end
		cm_t2_hit = cm_hit & ~cm_sel;
		set_hit   = hit(t2_upd, t2_cnt, r.set_val);
		clr_hit   = hit(t2_upd, t2_cnt, r.clr_val);
		port5_wr  = wsel(sfr_wr, sfr_addr, ADDR_PORT5);
		cc_m0_set = cc_hit & cc_cmp_en & ~cc_cmp_mode;
		cc_m0_clr = ~cc_hit & cc_cmp_en & ~cc_cmp_mode;
		m1_sel    = cc_cmp_en & cc_cmp_mode;
		cc_m1     = cc_hit & m1_sel;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [7:0] rv;
		rv     = 8'h00;
		next_r = r;

		// Byte writes to the 16-bit registers
		for (int i = 0; i < 5; i++)
		begin
			if (wsel(sfr_wr, sfr_addr, CC_LO_ADDR[i]))
			begin
				// Software capture or plain byte store
				if (cap_en[i] && cap_mode[i])
					next_r.cap_cmp[i] = t2_cnt;
				else
					next_r.cap_cmp[i][7:0] = sfr_wdata;
			end
			if (wsel(sfr_wr, sfr_addr, CC_HI_ADDR[i]))
				next_r.cap_cmp[i][15:8] = sfr_wdata;
		end
		for (int i = 0; i < 4; i++)
		begin
			// Pin capture wins over a byte write
			if (cap_go[i])
				next_r.cap_cmp[i] = t2_cnt;
		end
		for (int i = 0; i < 8; i++)
		begin
			if (wsel(sfr_wr, sfr_addr, CM_LO_ADDR[i]))
				next_r.general_compare_regs[i][7:0] = sfr_wdata;
			if (wsel(sfr_wr, sfr_addr, CM_HI_ADDR[i]))
				next_r.general_compare_regs[i][15:8] = sfr_wdata;
		end
		if (wsel(sfr_wr, sfr_addr, ADDR_SET_LO))
			next_r.set_val[7:0] = sfr_wdata;
		if (wsel(sfr_wr, sfr_addr, ADDR_SET_HI))
			next_r.set_val[15:8] = sfr_wdata;
		if (wsel(sfr_wr, sfr_addr, ADDR_CLR_LO))
			next_r.clr_val[7:0] = sfr_wdata;
		if (wsel(sfr_wr, sfr_addr, ADDR_CLR_HI))
			next_r.clr_val[15:8] = sfr_wdata;
		if (wsel(sfr_wr, sfr_addr, ADDR_CTR_LO))
			next_r.ct_rel[7:0] = sfr_wdata;
		if (wsel(sfr_wr, sfr_addr, ADDR_CTR_HI))
			next_r.ct_rel[15:8] = sfr_wdata;
		if (wsel(sfr_wr, sfr_addr, ADDR_SET_MSK))
			next_r.port5_set_mask = sfr_wdata;
		if (wsel(sfr_wr, sfr_addr, ADDR_CLR_MSK))
			next_r.port5_clear_mask = sfr_wdata;

		// Shadows follow the registers at compare overflow
		if (ct_ovf)
			next_r.shadow = r.general_compare_regs;

		// Compare/capture channel outputs
		for (int i = 0; i < 5; i++)
		begin
			if (cc_cmp_en[i] && !cc_cmp_mode[i])
			begin
				// Match first, then overflow clear
				if (cc_hit[i])
					next_r.cc_out[i] = 1'b1;
				else if (t2_ovf)
					next_r.cc_out[i] = 1'b0;
			end
			else if (cc_cmp_en[i] && cc_hit[i])
				next_r.cc_out[i] = cc_level[i];
		end

		// General compare outputs
		for (int i = 0; i < 8; i++)
		begin
			if (cm_en[i] && cm_sel[i])
			begin
				if (cm_hit[i])
					next_r.cm_out[i] = 1'b1;
				else if (ct_ovf)
					next_r.cm_out[i] = 1'b0;
			end
			else if (cm_hit[i])
				next_r.cm_out[i] = cm_level[i];
		end

		// Port 5: software write, then set, then clear
		if (port5_wr)
			next_r.port_five_reg = sfr_wdata;
		if (cm2_en && set_hit)
			next_r.port_five_reg = next_r.port_five_reg | r.port5_set_mask;
		if (cm2_en && clr_hit)
			next_r.port_five_reg = next_r.port_five_reg & ~r.port5_clear_mask;

		// Sticky flags, set wins over clear
		next_r.t2_flag  = (r.t2_flag & ~t2_ovf_clr) | t2_ovf;
		next_r.ext_flag = (r.ext_flag & ~ext_reload_clr)
		                | (reload_en && reload_mode && ext_fall && ext_reload_irq_en);
		next_r.cm_flag  = (r.cm_flag & ~cm_match_clr) | cm_t2_hit;
		next_r.ct_flag  = (r.ct_flag & ~ct_ovf_clr) | ct_ovf;
		next_r.set_flag = (r.set_flag & ~set_match_clr) | set_hit;
		next_r.clr_flag = (r.clr_flag & ~clear_match_clr) | clr_hit;

		// Pin history
		next_r.cap_prev = capture_input;
		next_r.ext_prev = ext_reload_pin;

		// Read data
		case (sfr_addr)
			ADDR_SET_LO:  rv = r.set_val[7:0];
			ADDR_SET_HI:  rv = r.set_val[15:8];
			ADDR_CLR_LO:  rv = r.clr_val[7:0];
			ADDR_CLR_HI:  rv = r.clr_val[15:8];
			ADDR_SET_MSK: rv = r.port5_set_mask;
			ADDR_CLR_MSK: rv = r.port5_clear_mask;
			ADDR_T2_LO:   rv = t2_cnt[7:0];
			ADDR_T2_HI:   rv = t2_cnt[15:8];
			ADDR_CTR_LO:  rv = r.ct_rel[7:0];
			ADDR_CTR_HI:  rv = r.ct_rel[15:8];
			ADDR_PORT5:   rv = port5_pin;
			default:      rv = 8'h00;
		endcase
		for (int i = 0; i < 5; i++)
		begin
			if (sfr_addr == CC_LO_ADDR[i])
				rv = r.cap_cmp[i][7:0];
			if (sfr_addr == CC_HI_ADDR[i])
				rv = r.cap_cmp[i][15:8];
		end
		for (int i = 0; i < 8; i++)
		begin
			if (sfr_addr == CM_LO_ADDR[i])
				rv = r.general_compare_regs[i][7:0];
			if (sfr_addr == CM_HI_ADDR[i])
				rv = r.general_compare_regs[i][15:8];
		end
		if (sfr_rd)
			next_r.rdata = rv;
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			r               <= '0;
			r.port_five_reg <= PORT5_RESET;
			// Pin histories start at the pulled-up idle level, no false edge
			r.cap_prev      <= '1;
			r.ext_prev      <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// Outputs: 5 + 8 + 8 lines
	// ------------------------------------------------------------
	assign sfr_rdata                   = r.rdata;
	assign cc_out_pin                  = r.cc_out;
	assign cm_out_pin                  = r.cm_out;
	assign port5_out                   = r.port_five_reg;
	assign general_timer_overflow_flag = r.t2_flag;
	assign ext_reload_flag             = r.ext_flag;
	assign general_compare_match_flag  = r.cm_flag;
	assign compare_timer_overflow_flag = r.ct_flag;
	assign set_match_flag              = r.set_flag;
	assign clear_match_flag            = r.clr_flag;
	assign irq_t2                      = r.t2_flag | r.ext_flag;
	assign irq_cm                      = |r.cm_flag;
	assign irq_ct                      = r.ct_flag;
	assign irq_set                     = r.set_flag;
	assign irq_clr                     = r.clr_flag;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_m0_set;
		@(posedge clk) disable iff (!rst_b)
		|cc_m0_set |=> ((r.cc_out & $past(cc_m0_set)) == $past(cc_m0_set));
	endproperty
	a_m0_set: assert property (p_m0_set)
		else $error("mode 0 match did not raise output");

	property p_m0_clr;
		@(posedge clk) disable iff (!rst_b)
		t2_ovf |=> ((r.cc_out & $past(cc_m0_clr)) == 5'h00);
	endproperty
	a_m0_clr: assert property (p_m0_clr)
		else $error("mode 0 output not cleared at overflow");

	property p_m1_level;
		@(posedge clk) disable iff (!rst_b)
		|cc_m1 |=> (((r.cc_out ^ $past(cc_level)) & $past(cc_m1)) == 5'h00);
	endproperty
	a_m1_level: assert property (p_m1_level)
		else $error("mode 1 match gave wrong level");

	property p_m1_hold;
		@(posedge clk) disable iff (!rst_b)
		(|m1_sel) && !(|cc_hit) |=>
			(((r.cc_out ^ $past(r.cc_out)) & $past(m1_sel)) == 5'h00);
	endproperty
	a_m1_hold: assert property (p_m1_hold)
		else $error("mode 1 output moved without a match");

	property p_p5_set;
		@(posedge clk) disable iff (!rst_b)
		cm2_en && set_hit && !clr_hit && !port5_wr |=>
			((r.port_five_reg & $past(r.port5_set_mask)) == $past(r.port5_set_mask));
	endproperty
	a_p5_set: assert property (p_p5_set)
		else $error("set match did not raise masked pins");

	property p_p5_clr;
		@(posedge clk) disable iff (!rst_b)
		cm2_en && clr_hit |=> ((r.port_five_reg & $past(r.port5_clear_mask)) == 8'h00);
	endproperty
	a_p5_clr: assert property (p_p5_clr)
		else $error("clear match did not lower masked pins");

	property p_auto_reload;
		@(posedge clk) disable iff (!rst_b)
		t2_ovf && reload_en && !reload_mode |=> (t2_cnt == $past(reload_value));
	endproperty
	a_auto_reload: assert property (p_auto_reload)
		else $error("overflow did not reload the general timer");

	property p_ext_reload;
		@(posedge clk) disable iff (!rst_b)
		ext_fall && reload_en && reload_mode && !t2_wr_lo && !t2_wr_hi |=>
			(t2_cnt == $past(reload_value)) && t2_upd;
	endproperty
	a_ext_reload: assert property (p_ext_reload)
		else $error("reload pin edge did not reload the general timer");

	property p_shadow;
		@(posedge clk) disable iff (!rst_b)
		ct_ovf |=> (r.shadow == $past(r.general_compare_regs));
	endproperty
	a_shadow: assert property (p_shadow)
		else $error("shadow latches not reloaded at overflow");

	property p_cm_flag;
		@(posedge clk) disable iff (!rst_b)
		|cm_t2_hit |=> ((r.cm_flag & $past(cm_t2_hit)) == $past(cm_t2_hit)) ##0 irq_cm;
	endproperty
	a_cm_flag: assert property (p_cm_flag)
		else $error("general match did not request an interrupt");

	property p_ct_flag;
		@(posedge clk) disable iff (!rst_b)
		ct_ovf |=> r.ct_flag && irq_ct;
	endproperty
	a_ct_flag: assert property (p_ct_flag)
		else $error("compare overflow did not request an interrupt");

	for (genvar g = 0; g < 4; g++)
	begin : g_cap
		property p_cap;
			@(posedge clk) disable iff (!rst_b)
			cap_go[g] |=> (r.cap_cmp[g] == $past(t2_cnt));
		endproperty
		a_cap: assert property (p_cap)
			else $error("pin capture did not store the timer");
	end

endmodule : ccu_compare_capture

/* File: ccu_pin_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port 5 pins, read back straight from the output latch
// ------------------------------------------------------------
module ccu_pin_model
(
	input  wire logic [7:0] port5_out,
	output logic      [7:0] port5_pin
);
	// Pin reads back the driven latch level
	assign port5_pin = port5_out;
endmodule : ccu_pin_model

/* File: ccu_pkg.sv */
package ccu_pkg;

	// ------------------------------------------------------------
	// Timing: clk taken as the oscillator
	// ------------------------------------------------------------
	localparam logic [7:0]       T2_BASE_DIV  = 8'h0c; // Osc cycles per general step
	localparam logic [7:0]       CT_BASE_DIV  = 8'h02; // Osc cycles per compare step
	localparam int               T2_PRE_W     = 2;     // General prescaler width
	localparam int               CT_PRE_W     = 8;     // Compare prescaler width
	localparam logic [15:0]      CNT_MAX      = 16'hffff;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]       PORT5_RESET  = 8'hff;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0]       ADDR_SET_LO  = 8'ha1; // Set compare value
	localparam logic [7:0]       ADDR_SET_HI  = 8'ha2;
	localparam logic [7:0]       ADDR_CLR_LO  = 8'ha3; // Clear compare value
	localparam logic [7:0]       ADDR_CLR_HI  = 8'ha4;
	localparam logic [7:0]       ADDR_SET_MSK = 8'ha5; // port5_set_mask
	localparam logic [7:0]       ADDR_CLR_MSK = 8'ha6; // port5_clear_mask
	localparam logic [7:0]       ADDR_T2_LO   = 8'hcc; // General timer count
	localparam logic [7:0]       ADDR_T2_HI   = 8'hcd;
	localparam logic [7:0]       ADDR_CTR_LO  = 8'hde; // Compare timer reload
	localparam logic [7:0]       ADDR_CTR_HI  = 8'hdf;
	localparam logic [7:0]       ADDR_PORT5   = 8'hf8; // port_five_reg
	// Index 0 is the reload register, 1..4 the capture registers
	localparam logic [4:0][7:0]  CC_LO_ADDR   = {8'hce, 8'hc6, 8'hc4, 8'hc2, 8'hca};
	localparam logic [4:0][7:0]  CC_HI_ADDR   = {8'hcf, 8'hc7, 8'hc5, 8'hc3, 8'hcb};
	localparam logic [7:0][7:0]  CM_LO_ADDR   = {8'hf4, 8'hf2, 8'he6, 8'he4,
	                                             8'he2, 8'hd6, 8'hd4, 8'hd2};
	localparam logic [7:0][7:0]  CM_HI_ADDR   = {8'hf5, 8'hf3, 8'he7, 8'he5,
	                                             8'he3, 8'hd7, 8'hd5, 8'hd3};

endpackage : ccu_pkg

/* File: ccu_timer.sv */
`timescale 1ns/1ps
module ccu_timer
	import ccu_pkg::*;
#(
	parameter logic [7:0] BASE_DIV = T2_BASE_DIV, // Clock cycles per base step
	parameter int         PRE_W    = T2_PRE_W     // Prescaler width
)
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             run,
	input  wire logic [PRE_W-1:0] pre_div,
	input  wire logic             load,
	input  wire logic [15:0]      load_val,
	input  wire logic             wr_lo,
	input  wire logic             wr_hi,
	input  wire logic [7:0]       wdata,
	output logic      [15:0]      cnt,
	output logic                  ovf,
	output logic                  upd
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]       base; // Base rate divider
		logic [PRE_W-1:0] pre;  // Prescaler
		logic [15:0]      cnt;  // Count
		logic             upd;  // Count just changed
	} ccu_tmr_s;

	ccu_tmr_s r;
	ccu_tmr_s next_r;
	logic     base_tick;
	logic     tick;

	// ------------------------------------------------------------
	// Step enables and overflow
	// ------------------------------------------------------------
	always_comb
	begin
		base_tick = (r.base == BASE_DIV - 8'h01);
		tick      = run && base_tick && (r.pre == pre_div);
		ovf       = tick && (r.cnt == CNT_MAX) && !wr_lo && !wr_hi;
	end

	// Next state: write, then load, then count
	always_comb
	begin
		next_r     = r;
		next_r.upd = 1'b0;
		next_r.base = base_tick ? 8'h00 : r.base + 8'h01;
		if (run && base_tick)
		begin
			next_r.pre = (r.pre == pre_div) ? '0 : r.pre + 1'b1;
		end
		if (wr_lo)
		begin
			next_r.cnt[7:0] = wdata;
		end
		else if (wr_hi)
		begin
			next_r.cnt[15:8] = wdata;
		end
		else if (load)
		begin
			next_r.cnt = load_val;
			next_r.upd = 1'b1;
		end
		else if (tick)
		begin
			next_r.cnt = r.cnt + 16'h0001;
			next_r.upd = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign cnt = r.cnt;
	assign upd = r.upd;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_base_gap;
		@(posedge clk) disable iff (!rst_b)
		base_tick |=> !base_tick;
	endproperty
	a_base_gap: assert property (p_base_gap)
		else $error("timer stepped faster than its base rate");

endmodule : ccu_timer

/* File: compare_capture_unit_bench.sv */
`timescale 1ns/1ps
module compare_capture_unit_bench
	import ccu_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, t2_run = 0, reload_en = 0;
	logic reload_mode = 0, ext_reload_irq_en = 0, ext_reload_pin = 1, ct_run = 0;
	logic cm2_en = 0, t2_ovf_clr = 0, ext_reload_clr = 0, ct_ovf_clr = 0;
	logic set_match_clr = 0, clear_match_clr = 0;
	logic [1:0] t2_pre_div = 0;
	logic [3:0] cap_rise = 0, capture_input = 0;
	logic [4:0] cc_cmp_en = 0, cc_cmp_mode = 0, cc_level = 0, cap_en = 0, cap_mode = 0;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, ct_pre_div = 0, cm_en = 0, cm_sel = 0;
	logic [7:0] cm_level = 0, cm_match_clr = 0, port5_pin, sfr_rdata, port5_out;
	logic [7:0] general_compare_match_flag, cm_out_pin, d;
	logic [4:0] cc_out_pin;
	logic general_timer_overflow_flag, ext_reload_flag, compare_timer_overflow_flag;
	logic set_match_flag, clear_match_flag, irq_t2, irq_cm, irq_ct, irq_set, irq_clr;
	logic [15:0] v;
	int error_cnt = 0;
	int comparisons = 0;

	ccu_compare_capture DUT (.*);
	ccu_pin_model pins (.port5_out(port5_out), .port5_pin(port5_pin));

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// ------------------------------------------------------------
	// Bus tasks and checks
	// ------------------------------------------------------------
	task wr(input logic [7:0] a, input logic [7:0] w);
		@(negedge clk) sfr_addr = a;
		sfr_wdata = w;
		sfr_wr = 1;
		@(negedge clk) sfr_wr = 0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] r);
		@(negedge clk) sfr_addr = a;
		sfr_rd = 1;
		@(negedge clk) sfr_rd = 0;
		r = sfr_rdata;
	endtask : rd

	task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk

	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	// Watchdog for a hung run
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		print_verdict;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(1));
		repeat (5) @(negedge clk);
		rst_b = 1;
		@(negedge clk);
		chk(port5_out, 8'hff, "port5 reset");
		chk({cm_out_pin[5:0], irq_ct, compare_timer_overflow_flag}, 8'h00, "reset outputs");
		rd(8'h90, d);
		chk(d, 8'h00, "unmapped read");
		$display("test reset done");
		// Random bytes into every general compare register
		for (int i = 0; i < 8; i++)
		begin
			v = 16'($urandom);
			wr(CM_LO_ADDR[i], v[7:0]);
			wr(CM_HI_ADDR[i], v[15:8]);
			rd(CM_LO_ADDR[i], d);
			chk(d, v[7:0], "compare low byte");
			rd(CM_HI_ADDR[i], d);
			chk(d, v[15:8], "compare high byte");
		end
		$display("test registers done");
		// Software capture on all five channels
		cap_en = 5'h1f;
		cap_mode = 5'h1f;
		for (int i = 0; i < 5; i++)
		begin
			v = 16'($urandom);
			wr(ADDR_T2_LO, v[7:0]);
			wr(ADDR_T2_HI, v[15:8]);
			wr(CC_LO_ADDR[i], 8'h5a);
			rd(CC_LO_ADDR[i], d);
			chk(d, v[7:0], "capture low");
			rd(CC_HI_ADDR[i], d);
			chk(d, v[15:8], "capture high");
		end
		cap_en = 0;
		$display("test capture done");
		// Port 5 set and clear matches
		cm2_en = 1;
		wr(ADDR_PORT5, 8'h00);
		rd(ADDR_PORT5, d);
		chk(d, 8'h00, "port5 direct write");
		wr(ADDR_SET_LO, 8'h10);
		wr(ADDR_SET_HI, 8'h00);
		wr(ADDR_CLR_LO, 8'h20);
		wr(ADDR_CLR_HI, 8'h00);
		wr(ADDR_SET_MSK, 8'h0f);
		wr(ADDR_CLR_MSK, 8'h03);
		wr(ADDR_T2_LO, 8'h0e);
		wr(ADDR_T2_HI, 8'h00);
		t2_run = 1;
		repeat (40) @(negedge clk);
		chk(port5_out, 8'h0f, "set match");
		chk({6'h00, irq_set, set_match_flag}, 8'h03, "set request");
		repeat (200) @(negedge clk);
		chk(port5_out, 8'h0c, "clear match");
		chk({6'h00, irq_clr, clear_match_flag}, 8'h03, "clear flag");
		$display("test mode 2 done");
		// Auto-reload at overflow
		t2_run = 0;
		reload_en = 1;
		wr(CC_LO_ADDR[0], 8'h00);
		wr(CC_HI_ADDR[0], 8'h80);
		wr(ADDR_T2_LO, 8'hfe);
		wr(ADDR_T2_HI, 8'hff);
		t2_run = 1;
		repeat (40) @(negedge clk);
		t2_run = 0;
		rd(ADDR_T2_HI, d);
		chk(d, 8'h80, "reload value");
		chk({7'h00, irq_t2}, 8'h01, "overflow request");
		t2_ovf_clr = 1;
		@(negedge clk) t2_ovf_clr = 0;
		@(negedge clk);
		chk({7'h00, irq_t2}, 8'h00, "overflow cleared");
		$display("test reload done");
		// Mode 0 and mode 1 outputs on the general timer
		cc_cmp_en = 5'h03;
		cc_cmp_mode = 5'h02;
		cc_level = 5'h02;
		cm_en = 8'h01;
		cm_level = 8'h01;
		wr(CC_LO_ADDR[1], 8'h04);
		wr(CC_HI_ADDR[1], 8'h80);
		wr(CM_LO_ADDR[0], 8'h06);
		wr(CM_HI_ADDR[0], 8'h80);
		wr(ADDR_T2_LO, 8'hfe);
		wr(ADDR_T2_HI, 8'h7f);
		t2_run = 1;
		repeat (110) @(negedge clk);
		t2_run = 0;
		chk({3'h0, cc_out_pin}, 8'h03, "match outputs");
		chk(cm_out_pin, 8'h01, "general compare output");
		chk(general_compare_match_flag, 8'h01, "general match flag");
		chk({7'h00, irq_cm}, 8'h01, "general match request");
		// Wrap without reload clears mode 0 only
		reload_en = 0;
		wr(ADDR_T2_LO, 8'hfe);
		wr(ADDR_T2_HI, 8'hff);
		t2_run = 1;
		repeat (30) @(negedge clk);
		t2_run = 0;
		chk({3'h0, cc_out_pin}, 8'h02, "overflow output");
		chk({7'h00, general_timer_overflow_flag}, 8'h01, "overflow flag");
		$display("test compare done");
		// Pin capture, then pin reload
		cap_en = 5'h04;
		cap_mode = 5'h00;
		cap_rise = 4'h4;
		v = 16'($urandom) & 16'h7fff;
		wr(ADDR_T2_LO, v[7:0]);
		wr(ADDR_T2_HI, v[15:8]);
		capture_input = 4'h4;
		rd(CC_LO_ADDR[2], d);
		chk(d, v[7:0], "pin capture low");
		rd(CC_HI_ADDR[2], d);
		chk(d, v[15:8], "pin capture high");
		reload_en = 1;
		reload_mode = 1;
		ext_reload_irq_en = 1;
		ext_reload_pin = 0;
		@(negedge clk) ext_reload_pin = 1;
		rd(ADDR_T2_HI, d);
		chk(d, 8'h80, "pin reload");
		chk({7'h00, ext_reload_flag}, 8'h01, "pin reload flag");
		$display("test pin events done");
		print_verdict;
	end
endmodule : compare_capture_unit_bench
